// *** src/pmx_pkg.sv ***
// ----------------------------------------------------------------------
// Shared constants of the pin function multiplexer
// ----------------------------------------------------------------------
package pmx_pkg;
    // Register bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Pin control register layout
    localparam int CTRL_W    = 8;
    localparam int MUX_LSB   = 0;
    localparam int MUX_W     = 2;
    localparam int GATE_LSB  = 2;
    localparam int GATE_W    = 2;
    localparam int F_OUT_EN  = 4;
    localparam int F_OPEN_DR = 5;
    localparam int F_OUT_VAL = 6;
    localparam int F_INT_EN  = 7;

    // Field values
    localparam logic [MUX_W-1:0]  MUX_GPIO   = 2'h0;
    localparam logic [GATE_W-1:0] GATE_IN_OFF = 2'h3;
    // Mux 0, input buffer off, driver off, interrupt off
    localparam logic [CTRL_W-1:0] CTRL_RST   = 8'h0C;

    // Register offsets
    localparam logic [ADDR_W-1:0] PIN_CTRL_BASE = 8'h00;
    localparam logic [ADDR_W-1:0] SW_CTRL_OFS   = 8'h40;
    localparam logic [ADDR_W-1:0] STATUS_OFS    = 8'h44;
    localparam int                STATUS_PAD_LSB = 16;
    localparam int                WORD_BYTES     = 4;

    // Structure limits
    localparam int ALT_NUM  = 3;
    localparam int MAX_PINS = 16;
endpackage

// *** src/pmx_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Raw and synchronised pad levels between the synchroniser and the mux
// ----------------------------------------------------------------------
interface pmx_sync_if #(
    parameter int NUM_PINS = 4
);
    logic [NUM_PINS-1:0] pad_raw;   // Pad levels from the pins
    logic [NUM_PINS-1:0] well_raw;  // Power well good levels
    logic [NUM_PINS-1:0] pad_s;     // Synchronised pad levels
    logic [NUM_PINS-1:0] well_s;    // Synchronised well good levels

    modport sync (input pad_raw, input well_raw, output pad_s, output well_s);
    modport user (output pad_raw, output well_raw, input pad_s, input well_s);
endinterface
`default_nettype wire

// *** src/pmx_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Two-stage synchroniser for pad and power well levels
// ----------------------------------------------------------------------
module pmx_sync #(
    parameter int NUM_PINS = 4
) (
    input  wire logic clk_sys_i,  // System clock
    input  wire logic rst_n_i,    // Asynchronous reset, active low
    pmx_sync_if.sync  sif         // Raw in, synchronised out
);
    typedef struct packed {
        logic [NUM_PINS-1:0] pad_m;
        logic [NUM_PINS-1:0] well_m;
        logic [NUM_PINS-1:0] pad_s;
        logic [NUM_PINS-1:0] well_s;
    } pmx_sync_st_t;

    pmx_sync_st_t st;
    pmx_sync_st_t next_st;

    // First stage feeds only the second stage
    always_comb begin
        next_st        = st;
        next_st.pad_m  = sif.pad_raw;
        next_st.well_m = sif.well_raw;
        next_st.pad_s  = st.pad_m;
        next_st.well_s = st.well_m;
    end

    // State register; wells read as not good during reset
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sif.pad_s  = st.pad_s;
    assign sif.well_s = st.well_s;
endmodule
`default_nettype wire

// *** src/pmx_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
module pmx_mux
    import pmx_pkg::*;
#(
    parameter int                             NUM_PINS = 4,
    parameter int                             NUM_SW   = 2,
    parameter logic [NUM_PINS-1:0]            HAS_GPIO = 4'h7,
    parameter logic [NUM_PINS*ALT_NUM-1:0]    ALT_PRESENT = 12'h3DB,
    parameter logic [NUM_PINS*ALT_NUM-1:0]    ALT_UNGATED = 12'h800,
    parameter logic [NUM_PINS*ALT_NUM-1:0]    ALT_LEVEL   = 12'h2A5
) (
    input  wire logic [ADDR_W-1:0]           addr_i,         // Register address
    input  wire logic [DATA_W-1:0]           wdata_i,        // Write data
    input  wire logic                        wr_i,           // Write strobe
    input  wire logic                        rd_i,           // Read strobe
    output var  logic [DATA_W-1:0]           rdata_o,        // Read data
    input  wire logic [NUM_PINS-1:0]         pad_in_i,       // Pad levels
    input  wire logic [NUM_PINS-1:0]         well_good_i,    // Well powered
    input  wire logic [NUM_PINS*ALT_NUM-1:0] periph_out_i,   // Periph drive
    input  wire logic [NUM_PINS*ALT_NUM-1:0] periph_oe_i,    // Periph enable
    output var  logic [NUM_PINS-1:0]         pad_out_o,      // Pad drive value
    output var  logic [NUM_PINS-1:0]         pad_oe_o,       // Pad drive on
    output var  logic [NUM_PINS-1:0]         pull_dn_o,      // Weak pull-down
    output var  logic [NUM_PINS*ALT_NUM-1:0] alt_in_o,       // Periph inputs
    output var  logic [NUM_PINS-1:0]         gpio_int_o,     // GPIO int level
    output var  logic [NUM_SW-1:0]           switch_close_o, // Pass switches
    input  wire logic                        clk_sys_i,      // System clock
    input  wire logic                        rst_n_i         // Reset, low
);
    localparam int NA = NUM_PINS * ALT_NUM;
    localparam logic [ADDR_W-1:0] CTRL_END =
        ADDR_W'(int'(PIN_CTRL_BASE) + WORD_BYTES * NUM_PINS);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (NUM_PINS < 1 || NUM_PINS > MAX_PINS) begin : g_bad_pins
        $error("NUM_PINS out of range");
    end
    if (NUM_SW < 1 || NUM_SW > DATA_W) begin : g_bad_sw
        $error("NUM_SW out of range");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_PINS-1:0][CTRL_W-1:0] ctrl;
        logic [NUM_SW-1:0]               sw;
        logic [DATA_W-1:0]               rdata;
        logic [NUM_PINS-1:0]             pad_out;
        logic [NUM_PINS-1:0]             pad_oe;
        logic [NUM_PINS-1:0]             pull_dn;
        logic [NUM_PINS-1:0]             int_req;
        logic [NA-1:0]                   alt_in;
        logic                            wr_seen;
    } pmx_state_t;

    pmx_state_t st;
    pmx_state_t next_st;

    pmx_sync_if #(.NUM_PINS(NUM_PINS)) sif ();

    // Pad and well levels cross into the clock domain
    assign sif.pad_raw  = pad_in_i;
    assign sif.well_raw = well_good_i;

    pmx_sync #(
        .NUM_PINS (NUM_PINS)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .sif       (sif)
    );

    // ------------------------------------------------------------------
    // Field helpers
    // ------------------------------------------------------------------
    function automatic logic [MUX_W-1:0] mux_of(
        input logic [CTRL_W-1:0] c
    );
        return c[MUX_LSB +: MUX_W];
    endfunction

    function automatic logic in_on(input logic [CTRL_W-1:0] c);
        return c[GATE_LSB +: GATE_W] != GATE_IN_OFF;
    endfunction

    function automatic logic ctrl_hit(input logic [ADDR_W-1:0] a);
        return a >= PIN_CTRL_BASE && a < CTRL_END
               && int'(a) % WORD_BYTES == 0;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [ADDR_W-3:0] idx;
        logic [CTRL_W-1:0] c;
        logic [MUX_W-1:0]  sel;
        logic              well;
        logic              on;
        int                j;
        idx   = '0;
        c     = '0;
        sel   = '0;
        well  = 1'b0;
        on    = 1'b0;
        j     = 0;
        next_st       = st;
        next_st.rdata = '0;
        idx = (ADDR_W-2)'((addr_i - PIN_CTRL_BASE) / WORD_BYTES);

        // Register writes
        if (wr_i) begin
            next_st.wr_seen = 1'b1;
            if (ctrl_hit(addr_i)) begin
                next_st.ctrl[idx] = wdata_i[CTRL_W-1:0];
            end else if (addr_i == SW_CTRL_OFS) begin
                next_st.sw = wdata_i[NUM_SW-1:0];
            end
        end

        // Register reads, data stand one cycle later
        if (rd_i) begin
            if (ctrl_hit(addr_i)) begin
                next_st.rdata = DATA_W'(st.ctrl[idx]);
            end else if (addr_i == SW_CTRL_OFS) begin
                next_st.rdata = DATA_W'(st.sw);
            end else if (addr_i == STATUS_OFS) begin
                next_st.rdata = (DATA_W'(sif.pad_s) << STATUS_PAD_LSB)
                              | DATA_W'(sif.well_s);
            end
        end

        // Per pin pad path and internal inputs
        for (int i = 0; i < NUM_PINS; i++) begin
            c    = st.ctrl[i];
            sel  = mux_of(c);
            well = sif.well_s[i];
            on   = in_on(c);
            next_st.pad_out[i] = 1'b0;
            next_st.pad_oe[i]  = 1'b0;
            if (sel == MUX_GPIO) begin
                // Open drain only ever drives low
                next_st.pad_out[i] = c[F_OUT_VAL] & ~c[F_OPEN_DR];
                next_st.pad_oe[i]  = c[F_OUT_EN]
                                   & (~c[F_OPEN_DR] | ~c[F_OUT_VAL]);
            end else begin
                j = i * ALT_NUM + int'(sel) - 1;
                if (ALT_PRESENT[j]) begin
                    // Peripheral drives the pad, never a gated level
                    next_st.pad_out[i] = periph_out_i[j];
                    next_st.pad_oe[i]  = periph_oe_i[j];
                end
            end
            // Input-only pins and ramping wells never drive
            if (!HAS_GPIO[i] || !well) begin
                next_st.pad_oe[i] = 1'b0;
            end
            next_st.pull_dn[i] = ~well;
            next_st.int_req[i] = c[F_INT_EN] & on & well
                               & (sel == MUX_GPIO) & sif.pad_s[i];
            for (int k = 0; k < ALT_NUM; k++) begin
                j = i * ALT_NUM + k;
                if (ALT_UNGATED[j]) begin
                    next_st.alt_in[j] = sif.pad_s[i];
                end else if (well && on && ALT_PRESENT[j]
                             && sel == MUX_W'(k + 1)) begin
                    next_st.alt_in[j] = sif.pad_s[i];
                end else begin
                    next_st.alt_in[j] = ALT_LEVEL[j];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st         <= '0;
            st.ctrl    <= {NUM_PINS{CTRL_RST}};
            st.sw      <= '0;
            st.pull_dn <= '1;
            st.alt_in  <= ALT_LEVEL;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign rdata_o        = st.rdata;
    assign pad_out_o      = st.pad_out;
    assign pad_oe_o       = st.pad_oe;
    assign pull_dn_o      = st.pull_dn;
    assign alt_in_o       = st.alt_in;
    assign gpio_int_o     = st.int_req;
    assign switch_close_o = st.sw;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_sw_write;
        wr_i && addr_i == SW_CTRL_OFS;
    endsequence

    sequence s_untouched;
        !st.wr_seen;
    endsequence

    a_reset_gpio_idle: assert property (
        s_untouched |-> (pad_oe_o == '0 && gpio_int_o == '0
                         && mux_of(st.ctrl[0]) == MUX_GPIO))
        else $error("pin not idle GPIO before first write");

    a_input_only: assert property (
        (pad_oe_o & ~HAS_GPIO) == '0)
        else $error("input-only pin drives pad");

    a_switch_open: assert property (
        s_untouched |-> switch_close_o == '0)
        else $error("pass switch closed before configured");

    a_switch_hold: assert property (
        !(wr_i && addr_i == SW_CTRL_OFS) |=> $stable(switch_close_o))
        else $error("pass switch moved without a write");

    a_switch_write: assert property (
        s_sw_write |=> switch_close_o == $past(wdata_i[NUM_SW-1:0]))
        else $error("pass switch not set by write");

    a_ramp_float: assert property (
        1'b1 |=> ((pad_oe_o & ~$past(sif.well_s)) == '0
                  && (pull_dn_o & ~$past(sif.well_s)) == ~$past(sif.well_s)))
        else $error("pin driven or not pulled down while ramping");

    a_pd_release: assert property (
        $rose(sif.well_s[0]) |=> !pull_dn_o[0] ##1 $stable(pull_dn_o[0]))
        else $error("pull-down not released after well good");

    for (genvar gi = 0; gi < NUM_PINS; gi++) begin : g_pin_chk
        a_pgs_int_off: assert property (
            !in_on(st.ctrl[gi]) |=> !gpio_int_o[gi])
            else $error("input event seen with buffer off");

        a_pd_free: assert property (
            sif.well_s[gi] |=> !pull_dn_o[gi])
            else $error("pull-down held with well good");

        a_gpio_drive: assert property (
            (HAS_GPIO[gi] && sif.well_s[gi] && !st.ctrl[gi][F_OPEN_DR]
             && mux_of(st.ctrl[gi]) == MUX_GPIO)
            |=> pad_out_o[gi] == $past(st.ctrl[gi][F_OUT_VAL])
                && pad_oe_o[gi] == $past(st.ctrl[gi][F_OUT_EN]))
            else $error("GPIO pad not driven from its control");

        for (genvar gk = 0; gk < ALT_NUM; gk++) begin : g_alt_chk
            localparam int J = gi * ALT_NUM + gk;

            a_alt_gated: assert property (
                (!ALT_UNGATED[J] && (mux_of(st.ctrl[gi]) != MUX_W'(gk + 1)
                 || !sif.well_s[gi] || !in_on(st.ctrl[gi])))
                |=> alt_in_o[J] == ALT_LEVEL[J])
                else $error("unselected input not at gated level");

            a_alt_ungated: assert property (
                ALT_UNGATED[J] |=> alt_in_o[J] == $past(sif.pad_s[gi]))
                else $error("ungated input does not follow pad");

            a_pad_from_periph: assert property (
                (ALT_PRESENT[J] && HAS_GPIO[gi] && sif.well_s[gi]
                 && mux_of(st.ctrl[gi]) == MUX_W'(gk + 1))
                |=> pad_out_o[gi] == $past(periph_out_i[J])
                    && pad_oe_o[gi] == $past(periph_oe_i[J]))
                else $error("pad not driven by selected peripheral");

            a_rsvd_quiet: assert property (
                (!ALT_PRESENT[J] && mux_of(st.ctrl[gi]) == MUX_W'(gk + 1))
                |=> !pad_oe_o[gi])
                else $error("reserved selection drives pad");
        end
    end
endmodule
`default_nettype wire

// *** test/pmx_mux_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module pmx_mux_test;
    import pmx_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus and bookkeeping
    // ------------------------------------------------------------------
    localparam logic [11:0] PRES = 12'h3DB;
    localparam logic [11:0] UNG  = 12'h008;
    localparam logic [11:0] LVL  = 12'h2A5;
    logic              clk_sys_i = 1'b0;
    logic              rst_n_i   = 1'b0;
    logic [ADDR_W-1:0] addr      = 8'h00;
    logic [DATA_W-1:0] wdata     = 32'h0;
    logic              wr        = 1'b0;
    logic              rd        = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [3:0]        pad       = 4'h0;
    logic [3:0]        well      = 4'h0;
    logic [11:0]       pout      = 12'h000;
    logic [11:0]       poe       = 12'h000;
    logic [3:0]        oe;
    logic [3:0]        po;
    logic [3:0]        pdn;
    logic [11:0]       ain;
    logic [3:0]        irq;
    logic [1:0]        sw;
    logic [31:0]       rnd       = 32'h8D689377;
    logic [31:0]       expq[$];
    logic              rd_seen   = 1'b0;
    int                error_cnt = 0;
    int                compares  = 0;
    int                cyc       = 0;

    // Clock at 10 MHz
    always #50 clk_sys_i = ~clk_sys_i;

    pmx_mux #(
        .NUM_PINS   (4),
        .NUM_SW     (2),
        .HAS_GPIO   (4'h7),
        .ALT_PRESENT(PRES),
        .ALT_UNGATED(UNG),
        .ALT_LEVEL  (LVL)
    ) uut (
        .addr_i        (addr),
        .wdata_i       (wdata),
        .wr_i          (wr),
        .rd_i          (rd),
        .rdata_o       (rdata),
        .pad_in_i      (pad),
        .well_good_i   (well),
        .periph_out_i  (pout),
        .periph_oe_i   (poe),
        .pad_out_o     (po),
        .pad_oe_o      (oe),
        .pull_dn_o     (pdn),
        .alt_in_o      (ain),
        .gpio_int_o    (irq),
        .switch_close_o(sw),
        .clk_sys_i     (clk_sys_i),
        .rst_n_i       (rst_n_i)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask

    // Read strobe; the expected word waits in the queue for the monitor
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        expq.push_back(e);
        @(posedge clk_sys_i);
        rd <= 1'b0;
    endtask

    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction

    // Expected internal inputs of one pin's three alternates
    function automatic logic [2:0] alt_exp(int p, int m, logic pd,
                                           logic wl, logic [1:0] pg);
        logic [2:0] r;
        int         j;
        for (int k = 0; k < 3; k++) begin
            j = p * 3 + k;
            if (UNG[j])
                r[k] = pd;
            else if (PRES[j] && m == k + 1 && wl && pg != 2'h3)
                r[k] = pd;
            else
                r[k] = LVL[j];
        end
        return r;
    endfunction

    // Read data stand in the cycle after the strobe only
    always @(posedge clk_sys_i) begin
        if (rd_seen) begin
            chk(rdata, expq.pop_front());
        end
        rd_seen <= rd;
    end

    // Hang guard
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [7:0]  tbl[3];
        logic [1:0]  tex[3];
        int          m;
        int          j;
        tbl = '{8'h50, 8'h70, 8'h30};
        tex = '{2'h3, 2'h0, 2'h2};
        repeat (12) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        step(1);
        chk(oe, 4'h0);
        chk(pdn, 4'hF);
        chk(ain, LVL);
        chk(irq, 4'h0);
        chk(sw, 2'h0);
        for (int i = 0; i < 4; i++) rdx(8'(4 * i), CTRL_RST);
        rdx(SW_CTRL_OFS, 32'h0);
        $display("Test reset done");
        @(posedge clk_sys_i);
        well <= 4'hF;
        step(2);
        chk(pdn, 4'hF);
        step(1);
        chk(pdn, 4'h0);
        chk(oe, 4'h0);
        $display("Test power done");
        for (int i = 0; i < 3; i++) begin
            wrr(8'h00, 32'(tbl[i]));
            step(1);
            chk({oe[0], po[0]}, tex[i]);
        end
        wrr(8'h0C, 32'h50);
        wrr(8'h08, 32'h50);
        step(1);
        chk(oe[3:2], 2'h1);
        $display("Test gpio done");
        @(posedge clk_sys_i);
        pad <= 4'h1;
        wrr(8'h00, 32'h80);
        step(1);
        chk(irq[0], 1'b1);
        wrr(8'h00, 32'h8C);
        step(1);
        chk(irq[0], 1'b0);
        wrr(8'h00, 32'h01);
        wrr(8'h00, 32'h0D);
        step(1);
        chk(ain[2:0], alt_exp(0, 1, 1'b1, 1'b1, 2'h3));
        $display("Test gating done");
        for (int i = 0; i < 12; i++) begin
            r = xs();
            m = i % 4;
            j = 3 + m - 1;
            @(posedge clk_sys_i);
            pad[1] <= r[2];
            pout[5:3] <= r[5:3];
            poe[5:3] <= r[8:6];
            wrr(8'h04, 32'(m));
            step(1);
            if (m == 0)
                chk({oe[1], po[1]}, 2'h0);
            else
                chk({oe[1], po[1]}, {PRES[j] & r[6 + m - 1],
                    PRES[j] & r[3 + m - 1]});
            chk(ain[5:3], alt_exp(1, m, r[2], 1'b1, 2'h0));
        end
        $display("Test mux done");
        wrr(8'h04, 32'h01);
        @(posedge clk_sys_i);
        poe[3] <= 1'b1;
        well <= 4'hD;
        pad[1] <= 1'b1;
        step(3);
        chk(oe[1], 1'b0);
        chk(pdn[1], 1'b1);
        chk(ain[3], 1'b1);
        wrr(8'h04, 32'h02);
        step(1);
        chk(ain[5:3], alt_exp(1, 2, 1'b1, 1'b0, 2'h0));
        $display("Test well done");
        wrr(SW_CTRL_OFS, 32'hFF);
        step(1);
        chk(sw, 2'h3);
        rdx(SW_CTRL_OFS, 32'h3);
        wrr(STATUS_OFS, 32'hFFFFFFFF);
        rdx(STATUS_OFS, {16'(pad), 16'(well)});
        rdx(8'h48, 32'h0);
        rdx(8'h01, 32'h0);
        $display("Test registers done");
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        step(2);
        chk(oe, 4'h0);
        chk(sw, 2'h0);
        chk(pdn, 4'hF);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rdx(8'h04, CTRL_RST);
        step(3);
        $display("Test rereset done");
        conclude();
    end
endmodule
`default_nettype wire
